// file: logic/itd_pkg.sv
package itd_pkg;

  // descriptor geometry
  localparam int DESC_DWORDS = 16;
  localparam int SLOT_COUNT = 8;
  localparam int PAGE_COUNT = 7;
  localparam logic [3:0] DW_LINK = 4'h0;
  localparam logic [3:0] DW_SLOT0 = 4'h1;
  localparam logic [3:0] DW_PAGE0 = 4'h9;
  localparam logic [3:0] DW_PAGE1 = 4'hA;
  localparam logic [3:0] DW_PAGE2 = 4'hB;

  // link dword fields
  localparam int LINK_TERM_BIT = 0;
  localparam int LINK_TYPE_LSB = 1;
  localparam int LINK_PTR_LSB = 5;

  // slot dword fields
  localparam int SLOT_STAT_LSB = 28;
  localparam int SLOT_LEN_LSB = 16;
  localparam int SLOT_IOC_BIT = 15;
  localparam int SLOT_PG_LSB = 12;
  localparam int STAT_ACTIVE = 3;
  localparam int STAT_BUFERR = 2;
  localparam int STAT_BABBLE = 1;
  localparam int STAT_XACTERR = 0;

  // page dword fields
  localparam int PAGE_LSB = 12;
  localparam int EPNUM_LSB = 8;
  localparam int DIR_BIT = 11;
  localparam int MULT_LSB = 0;

  // link type codes
  localparam logic [1:0] TYPE_ISO = 2'h0;
  localparam logic [1:0] TYPE_QUEUE = 2'h1;
  localparam logic [1:0] TYPE_SPLIT = 2'h2;
  localparam logic [1:0] TYPE_SPAN = 2'h3;
  localparam logic [10:0] MAX_PACKET_LIMIT = 11'h400;

  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_LINK = 8'h0C;
  localparam logic [7:0] REG_ADDR = 8'h10;
  localparam logic [7:0] REG_EPINFO = 8'h14;
  localparam logic [7:0] REG_RESULT = 8'h18;
  localparam logic [7:0] REG_COUNT = 8'h1C;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_WAIT = 3'b010,
    ST_EXEC = 3'b011,
    ST_WBACK = 3'b100,
    ST_DONE = 3'b101
  } itd_state_t;

  // memory request to system memory
  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } itd_mreq_t;

  // transaction result from packet engine
  typedef struct packed {
    logic done;
    logic buf_err;
    logic babble;
    logic xact_err;
    logic [11:0] count;
    logic [2:0] page_sel;
    logic [11:0] offset;
  } itd_xres_t;

endpackage

// file: logic/itd_engine.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module itd_engine #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system memory
  output itd_pkg::itd_mreq_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // packet engine
  input wire logic [2:0] uframe_idx,
  output logic xact_start,
  output logic [31:0] xact_addr,
  output logic [11:0] xact_len,
  input wire itd_pkg::itd_xres_t xact_res,
  output logic ioc_req
);

  // complete state of the engine, one flop bank
  typedef struct packed {
    itd_pkg::itd_state_t st;
    logic [3:0] idx;
    logic [31:0] base;
    logic [31:0] link;
    logic [31:0] slot;
    logic [19:0] pg;
    logic [31:0] dw9;
    logic [31:0] dw10;
    logic [31:0] dw11;
    logic busy;
    logic link_valid;
    logic mult_bad;
    logic skipped;
    logic [7:0] count;
    logic [31:0] result;
    itd_pkg::itd_mreq_t mreq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic xstart;
    logic [31:0] xaddr;
    logic [11:0] xlen;
    logic ioc;
  } itd_regs_t;

  itd_regs_t s_r;
  itd_regs_t s_nxt;
  logic [1:0] rst_sync_r;
  logic rst_int_b;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync_r[1];

  // byte address of a descriptor dword
  function automatic logic [31:0] dw_addr(input logic [31:0] base, input logic [3:0] dw);
    dw_addr = {base[31:6], 6'h00} + {26'h0, dw, 2'h0};
  endfunction

  // slot number to its dword index
  function automatic logic [3:0] slot_dw(input logic [2:0] n);
    slot_dw = itd_pkg::DW_SLOT0 + {1'b0, n};
  endfunction

  // fold one transaction result into the slot status nibble; errors only accumulate
  function automatic logic [3:0] fold_stat(input logic [3:0] old, input itd_pkg::itd_xres_t r);
    fold_stat = old;
    fold_stat[itd_pkg::STAT_ACTIVE] = 1'b0;
    fold_stat[itd_pkg::STAT_BUFERR] = old[itd_pkg::STAT_BUFERR] | r.buf_err;
    fold_stat[itd_pkg::STAT_BABBLE] = old[itd_pkg::STAT_BABBLE] | r.babble;
    fold_stat[itd_pkg::STAT_XACTERR] = old[itd_pkg::STAT_XACTERR] | r.xact_err;
  endfunction

  // endpoint info word; direction bit sits just above the size, so mask it out
  function automatic logic [31:0] ep_word(input logic [31:0] d10, input logic [31:0] d11);
    logic [10:0] max_packet_bytes;
    logic too_big;
    max_packet_bytes = d10[10:0];
    too_big = max_packet_bytes > itd_pkg::MAX_PACKET_LIMIT;
    ep_word = {d11[itd_pkg::MULT_LSB +: 2], 18'h0, too_big, max_packet_bytes};
  endfunction

  // fetched page dword is the one the slot selects; select 7 names no page
  function automatic logic page_hit(input logic [3:0] dw, input logic [2:0] sel);
    logic [4:0] rel;
    rel = {1'b0, dw} - {1'b0, itd_pkg::DW_PAGE0};
    page_hit = (sel < 3'(itd_pkg::PAGE_COUNT)) && (rel == {2'h0, sel});
  endfunction

  // only a valid link to another descriptor of this kind is chased
  function automatic logic follow_link(input logic [31:0] lnk);
    logic term;
    logic [1:0] kind;
    term = lnk[itd_pkg::LINK_TERM_BIT];
    kind = lnk[itd_pkg::LINK_TYPE_LSB +: 2];
    follow_link = !term && kind == itd_pkg::TYPE_ISO;
  endfunction

  // link pointer keeps its upper bits, type and terminate are masked off
  function automatic logic [31:0] link_target(input logic [31:0] lnk);
    link_target = {lnk[31:itd_pkg::LINK_PTR_LSB], 5'h00};
  endfunction

  // page select of a slot dword
  function automatic logic [2:0] slot_page(input logic [31:0] w);
    slot_page = w[itd_pkg::SLOT_PG_LSB +: 3];
  endfunction

  // byte length of a slot dword
  function automatic logic [11:0] slot_len(input logic [31:0] w);
    slot_len = w[itd_pkg::SLOT_LEN_LSB +: 12];
  endfunction

  // buffer offset of a slot dword, below the page select
  function automatic logic [11:0] slot_offset(input logic [31:0] w);
    slot_offset = w[itd_pkg::SLOT_PG_LSB-1:0];
  endfunction

  // multiplier code zero is reserved
  function automatic logic mult_reserved(input logic [31:0] w);
    mult_reserved = w[itd_pkg::MULT_LSB +: 2] == 2'h0;
  endfunction

  // direction bit of the page 1 dword, one means in
  function automatic logic is_in(input logic [31:0] w);
    is_in = w[itd_pkg::DIR_BIT];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [2:0] psel_pg;
    logic [11:0] off;
    logic dir_in;
    logic [3:0] sts;
    s_nxt = s_r;
    s_nxt.xstart = 1'b0;
    s_nxt.ioc = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    // fields of the fetched slot and endpoint dwords
    psel_pg = slot_page(s_r.slot);
    off = slot_offset(s_r.slot);
    dir_in = is_in(s_r.dw10);
    sts = s_r.slot[itd_pkg::SLOT_STAT_LSB +: 4];

    // apb: one wait state, answer in the access phase
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = itd_pkg::RST_WORD;
      if (paddr == itd_pkg::REG_CTRL) begin
        if (pwrite) begin
          if (pwdata[0] && !s_r.busy) begin
            s_nxt.busy = 1'b1;
            s_nxt.st = itd_pkg::ST_FETCH;
            s_nxt.idx = itd_pkg::DW_LINK;
          end
        end else begin
          s_nxt.prdata = {31'h0, s_r.busy};
        end
      end else if (paddr == itd_pkg::REG_BASE) begin
        if (pwrite && !s_r.busy) begin
          s_nxt.base = pwdata;
        end
        s_nxt.prdata = s_r.base;
      end else if (paddr == itd_pkg::REG_STAT) begin
        s_nxt.prdata = {24'h0, s_r.skipped, s_r.mult_bad, s_r.link_valid, 2'h0, s_r.st};
      end else if (paddr == itd_pkg::REG_LINK) begin
        s_nxt.prdata = s_r.link;
      end else if (paddr == itd_pkg::REG_ADDR) begin
        s_nxt.prdata = s_r.dw9;
      end else if (paddr == itd_pkg::REG_EPINFO) begin
        s_nxt.prdata = ep_word(s_r.dw10, s_r.dw11);
      end else if (paddr == itd_pkg::REG_RESULT) begin
        s_nxt.prdata = s_r.result;
      end else if (paddr == itd_pkg::REG_COUNT) begin
        s_nxt.prdata = {24'h0, s_r.count};
      end else begin
        s_nxt.pslverr = 1'b1; // unmapped
      end
    end

    case (s_r.st)
      // nothing to do until software starts a run
      itd_pkg::ST_IDLE: begin
        s_nxt.busy = s_nxt.busy;
      end
      // read link, slot of this microframe, then dwords 9..15
      itd_pkg::ST_FETCH: begin
        s_nxt.mreq.req = 1'b1;
        s_nxt.mreq.wr = 1'b0;
        s_nxt.mreq.addr = dw_addr(s_r.base, s_r.idx);
        s_nxt.st = itd_pkg::ST_WAIT;
      end
      // take the answer, then pick the next dword
      itd_pkg::ST_WAIT: begin
        if (mem_ack) begin
          s_nxt.mreq.req = 1'b0;
          if (s_r.mreq.wr) begin
            s_nxt.st = itd_pkg::ST_DONE;
            s_nxt.count = s_r.count + 8'h01;
          end else begin
            s_nxt.st = itd_pkg::ST_FETCH;
            if (s_r.idx == itd_pkg::DW_LINK) begin
              s_nxt.link = mem_rdata;
              s_nxt.link_valid = !mem_rdata[itd_pkg::LINK_TERM_BIT];
              s_nxt.idx = slot_dw(uframe_idx);
            end else if (s_r.idx < itd_pkg::DW_PAGE0) begin
              s_nxt.slot = mem_rdata;
              s_nxt.idx = itd_pkg::DW_PAGE0;
            end else begin
              if (s_r.idx == itd_pkg::DW_PAGE0) begin
                s_nxt.dw9 = mem_rdata;
              end
              if (s_r.idx == itd_pkg::DW_PAGE1) begin
                s_nxt.dw10 = mem_rdata;
              end
              if (s_r.idx == itd_pkg::DW_PAGE2) begin
                s_nxt.dw11 = mem_rdata;
                s_nxt.mult_bad = mult_reserved(mem_rdata);
              end
              if (page_hit(s_r.idx, psel_pg)) begin
                s_nxt.pg = mem_rdata[31:itd_pkg::PAGE_LSB];
              end
              if (s_r.idx == 4'(itd_pkg::DESC_DWORDS - 1)) begin
                s_nxt.st = itd_pkg::ST_EXEC;
              end else begin
                s_nxt.idx = s_r.idx + 4'h1;
              end
            end
          end
        end
      end
      // run the slot of this microframe, or skip it
      itd_pkg::ST_EXEC: begin
        if (!sts[itd_pkg::STAT_ACTIVE] || s_r.mult_bad) begin
          s_nxt.skipped = 1'b1;
          s_nxt.st = itd_pkg::ST_DONE;
        end else if (!s_r.xstart && !xact_res.done) begin
          s_nxt.skipped = 1'b0;
          s_nxt.xstart = !s_r.result[31];
          s_nxt.result[31] = 1'b1;
          s_nxt.xaddr = {s_r.pg, off};
          s_nxt.xlen = slot_len(s_r.slot);
        end else if (xact_res.done) begin
          s_nxt.result = itd_pkg::RST_WORD;
          s_nxt.slot[itd_pkg::SLOT_STAT_LSB +: 4] = fold_stat(sts, xact_res);
          if (dir_in) begin
            s_nxt.slot[itd_pkg::SLOT_LEN_LSB +: 12] = xact_res.count;
          end else begin
            s_nxt.slot[itd_pkg::SLOT_PG_LSB +: 3] = xact_res.page_sel;
            s_nxt.slot[11:0] = xact_res.offset;
          end
          s_nxt.ioc = s_r.slot[itd_pkg::SLOT_IOC_BIT];
          s_nxt.st = itd_pkg::ST_WBACK;
        end
      end
      // write the single executed slot back
      itd_pkg::ST_WBACK: begin
        s_nxt.mreq.req = 1'b1;
        s_nxt.mreq.wr = 1'b1;
        s_nxt.mreq.addr = dw_addr(s_r.base, slot_dw(uframe_idx));
        s_nxt.mreq.wdata = s_r.slot;
        s_nxt.result = s_r.slot;
        s_nxt.st = itd_pkg::ST_WAIT;
      end
      // release the engine and, over a followed link, load base with the next descriptor's address without starting it
      itd_pkg::ST_DONE: begin
        s_nxt.busy = 1'b0;
        s_nxt.st = itd_pkg::ST_IDLE;
        // follow link only to another iso descriptor of this kind
        if (follow_link(s_r.link)) begin
          s_nxt.base = link_target(s_r.link);
        end
      end
      default: begin
        s_nxt.st = itd_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // every output is a field of the state flop
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign mem_req = s_r.mreq;
  assign xact_start = s_r.xstart;
  assign xact_addr = s_r.xaddr;
  assign xact_len = s_r.xlen;
  assign ioc_req = s_r.ioc;

endmodule // itd_engine

// file: verif/itd_properties.sv
`timescale 1ns/100ps
module itd_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire itd_pkg::itd_mreq_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic [2:0] uframe_idx,
  input wire logic xact_start,
  input wire logic [31:0] xact_addr,
  input wire logic [11:0] xact_len,
  input wire itd_pkg::itd_xres_t xact_res,
  input wire logic ioc_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // bus answers: one wait state, single-cycle ready
  apb_wait_a:
    assert property ($rose(penable) && psel |=> pready) else $error("apb answer late");
  apb_pulse_a:
    assert property (pready |=> !pready) else $error("pready held high");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  // memory requests stay put until taken, then let go
  req_hold_a:
    assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req.addr))
      else $error("memory request changed before ack");
  req_drop_a:
    assert property (mem_req.req && mem_ack |=> !mem_req.req) else $error("request kept");
  // write-back goes only to the serviced slot, active cleared
  active_clear_a:
    assert property (mem_req.req && mem_req.wr |-> !mem_req.wdata[31])
      else $error("active left set");
  wb_slot_a:
    assert property (mem_req.req && mem_req.wr |-> mem_req.addr[5:2] == uframe_idx + 4'h1)
      else $error("write-back to wrong slot");
  ioc_after_a:
    assert property (ioc_req |-> $past(xact_res.done)) else $error("ioc without completion");
  start_pulse_a:
    assert property (xact_start |=> !xact_start) else $error("start not a pulse");
  cover property (xact_start);
  cover property (ioc_req);
  cover property (mem_req.req && mem_req.wr && mem_ack);
  cover property (pslverr);
endmodule // itd_checker

bind itd_engine itd_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk),
  .rst_b(rst_b),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .mem_req(mem_req),
  .mem_ack(mem_ack),
  .mem_rdata(mem_rdata),
  .uframe_idx(uframe_idx),
  .xact_start(xact_start),
  .xact_addr(xact_addr),
  .xact_len(xact_len),
  .xact_res(xact_res),
  .ioc_req(ioc_req)
);

// file: verif/itd_mem_model.sv
`timescale 1ns/100ps
module itd_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire itd_pkg::itd_mreq_t mem_req,
  input wire logic [1:0] lag,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [16];
  logic [1:0] cnt_r;
  ////////////////////////////////////////
  // idle data toggles so a stale read never looks right
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      cnt_r <= 2'h0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.req && !mem_ack) begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == lag) begin
          mem_ack <= 1'b1;
          cnt_r <= 2'h0;
          if (mem_req.wr)
            mem[mem_req.addr[5:2]] <= mem_req.wdata;
          else
            mem_rdata <= mem[mem_req.addr[5:2]];
        end
      end
    end
  end
endmodule // itd_mem_model

// file: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] uframe_idx = 3'h0;
  logic [1:0] lag = 2'h0;
  logic [31:0] prdata, mem_rdata, xact_addr, sa;
  logic [11:0] xact_len, sl;
  logic pready, pslverr, mem_ack, xact_start, ioc_req;
  itd_pkg::itd_mreq_t mem_req;
  itd_pkg::itd_xres_t xact_res = '0;
  itd_pkg::itd_xres_t res = '0;
  int errors = 0;
  int n_checks = 0;
  int xn = 0;
  int ion = 0;
  itd_engine u_dut (
    .clk(clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mem_req(mem_req),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .uframe_idx(uframe_idx),
    .xact_start(xact_start),
    .xact_addr(xact_addr),
    .xact_len(xact_len),
    .xact_res(xact_res),
    .ioc_req(ioc_req)
  );
  itd_mem_model u_mem (
    .clk(clk),
    .rst_b(rst_b),
    .mem_req(mem_req),
    .lag(lag),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );
  initial forever #50 clk = ~clk;
  // packet engine stand-in: result one cycle after each start
  always @(posedge clk) begin
    xact_res <= '0;
    if (xact_start === 1'b1) begin
      sa <= xact_addr;
      sl <= xact_len;
      xn <= xn + 1;
      xact_res <= res;
    end
    if (ioc_req === 1'b1)
      ion <= ion + 1;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until pready is seen at a rising edge; data taken and bus released there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic run(input logic [2:0] uf, input logic [31:0] base);
    logic [31:0] q;
    logic e;
    uframe_idx <= uf;
    xn = 0;
    ion = 0;
    apb(1'b1, itd_pkg::REG_BASE, base, q, e);
    apb(1'b1, itd_pkg::REG_CTRL, 32'h1, q, e);
    // only the watchdog ends a run that never goes idle
    do rd(itd_pkg::REG_CTRL, q); while (q[0] !== 1'b0);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(itd_pkg::REG_CTRL, q);
    chk("ctrl", q, itd_pkg::RST_WORD);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped", {31'h0, e}, 32'h1);
    $display("test regs done");
  endtask
  // in transfer, slow memory, errors and completion interrupt
  task automatic t_in();
    logic [31:0] q;
    for (int k = 12; k < 16; k++)
      u_mem.mem[k] = 32'(k) << 12;
    u_mem.mem[0] = 32'h0000_0040;
    u_mem.mem[4] = 32'h8200_A123;
    u_mem.mem[9] = 32'h0001_0512;
    u_mem.mem[10] = 32'h0002_0A00;
    u_mem.mem[11] = 32'h0003_0001;
    res = '{1'b1, 1'b1, 1'b0, 1'b1, 12'h1F0, 3'h2, 12'h123};
    lag <= 2'h3;
    run(3'h3, 32'h0000_0080);
    chk("in addr", sa, 32'h0003_0123);
    chk("in len", {20'h0, sl}, 32'h200);
    chk("in wb", u_mem.mem[4], 32'h51F0_A123);
    rd(itd_pkg::REG_RESULT, q);
    chk("result", q, 32'h51F0_A123);
    rd(itd_pkg::REG_LINK, q);
    chk("link", q, 32'h0000_0040);
    chk("ioc", ion, 1);
    rd(itd_pkg::REG_BASE, q);
    chk("next", q, 32'h0000_0040);
    rd(itd_pkg::REG_ADDR, q);
    chk("dw9", q, 32'h0001_0512);
    rd(itd_pkg::REG_EPINFO, q);
    chk("epinfo", q, 32'h4000_0200);
    $display("test in done");
  endtask
  // out transfer, fast memory, babble, terminated link
  task automatic t_out();
    logic [31:0] q;
    u_mem.mem[0] = 32'h0000_0103;
    u_mem.mem[1] = 32'h8100_0010;
    u_mem.mem[10] = 32'h0002_0200;
    u_mem.mem[11] = 32'h0003_0003;
    res = '{1'b1, 1'b0, 1'b1, 1'b0, 12'h0AA, 3'h1, 12'h110};
    lag <= 2'h0;
    run(3'h0, 32'h0000_0080);
    chk("out addr", sa, 32'h0001_0010);
    chk("out wb", u_mem.mem[1], 32'h2100_1110);
    chk("no ioc", ion, 0);
    rd(itd_pkg::REG_BASE, q);
    chk("term", q, 32'h0000_0080);
    rd(itd_pkg::REG_LINK, q);
    chk("link term", q, 32'h0000_0103);
    rd(itd_pkg::REG_STAT, q);
    chk("link invalid", {31'h0, q[5]}, 32'h0);
    rd(itd_pkg::REG_EPINFO, q);
    chk("mult3", q, 32'hC000_0200);
    $display("test out done");
  endtask
  // inactive slot, then reserved multiplier; queue and split links not followed
  task automatic t_skip();
    logic [31:0] q;
    for (int k = 0; k < 2; k++) begin
      u_mem.mem[0] = 32'h0000_0040 | (32'(k + 1) << 1);
      u_mem.mem[8] = k ? 32'h8100_0000 : 32'h0100_0000;
      u_mem.mem[10] = 32'h0002_0401;
      u_mem.mem[11] = k ? 32'h0003_0000 : 32'h0003_0001;
      run(3'h7, 32'h0000_0080);
      chk("no xact", xn, 0);
      chk("no wb", u_mem.mem[8], k ? 32'h8100_0000 : 32'h0100_0000);
      rd(itd_pkg::REG_STAT, q);
      chk("skip flag", {31'h0, q[7 - k]}, 32'h1);
      rd(itd_pkg::REG_COUNT, q);
      chk("count", q, 32'h2);
      rd(itd_pkg::REG_BASE, q);
      chk("type", q, 32'h0000_0080);
      rd(itd_pkg::REG_EPINFO, q);
      if (k == 1)
        chk("big mps", {20'h0, q[11:0]}, 32'hC01);
    end
    $display("test skip done");
  endtask
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_in();
    t_out();
    t_skip();
    stop_test();
  end
  // tests need a few hundred cycles; 20000 means a hang
  initial begin
    #2000000;
    errors++;
    stop_test();
  end
endmodule // testbench
